/* rtl/csbc_pkg.sv */
// Shared constants for the chip-select bank controller.
// Assumes APB with 32-bit data, byte addresses, one aligned word per register.
package csbc_pkg;
   localparam int NBANK = 4;
   // Register byte offsets
   localparam logic [11:0] OFS_MODE = 12'h000;
   localparam logic [11:0] OFS_ERR = 12'h004;
   localparam logic [11:0] OFS_STAT = 12'h008;
   localparam logic [11:0] OFS_WDOG = 12'h00c;
   localparam logic [11:0] OFS_BANK = 12'h020;
   localparam logic [11:0] OFS_BANK_END = 12'h040;
   // Mode register fields
   localparam int MODE_NARROW = 0;
   localparam int MODE_ADMUX = 1;
   // Error register field
   localparam int ERR_TIMEOUT = 0;
   // Watchdog register fields
   localparam int WDOG_PER_LO = 8;
   localparam int WDOG_ON = 7;
   localparam logic [7:0] WDOG_PER_RST = 8'hff;
   localparam int WDOG_STEP = 8;
   localparam int WDOG_BASE = 2;
   // Base register fields
   localparam int BR_ADDR_LO = 15;
   localparam int BR_PORT16 = 11;
   localparam int BR_ADMUX = 7;
   localparam int BR_BLEN = 6;
   localparam int BR_STROBE = 5;
   localparam int BR_TOGGLE = 4;
   localparam int BR_EXTACK = 2;
   localparam int BR_NOBURST = 1;
   localparam int BR_VALID = 0;
   localparam logic [31:0] BR_WMASK = 32'h1fff_88f7;
   localparam logic [31:0] BR_RST = 32'h2000_0002;
   localparam logic [2:0] BR_ADDR_FIX = 3'h1;
   // Option register fields
   localparam int OR_MASK_LO = 15;
   localparam int OR_FIRST_LO = 4;
   localparam int OR_LATER_LO = 1;
   localparam logic [31:0] OR_WMASK = 32'hffff_80f6;
   localparam logic [31:0] OR_RST = 32'he000_0000;
   localparam logic [2:0] OR_MASK_FIX = 3'h7;
   // Beats per burst by port width
   localparam logic [3:0] BEATS32 = 4'h4;
   localparam logic [3:0] BEATS16 = 4'h8;
   typedef enum logic [1:0] {CSBC_IDLE, CSBC_ADDR, CSBC_DATA} csbc_state_t;
endpackage : csbc_pkg

/* rtl/csbc_ctrl.sv */
// Chip-select bank controller: four base/option pairs, bank match, external cycle sequencing.
// Assumes APB registers on pclk; the external bus clock arrives as a plain input and is sampled.
// Behaviour
// - Strobe role 0 gives write enables, 1 gives byte enables.
// - Toggle 0 holds burst flag until the last beat; 1 only later-waits+1 cycles before beats.
// - Internal ack mode drives transfer ack; external mode waits for it as input.
// - External ack banks treat their no-burst flag as set.
// - No-burst flag forbids burst reads; resets to one.
// - A bank select only asserts when that bank is valid.
// - Wide bursts fetch four words: four beats at 32 bits, eight at 16.
// - No two-word external bursts are ever produced.
// - Cleared mask bits exclude address bits from the compare.
// - Top three mask bits are fixed ones.
// - First beat lasts two plus first waits; ignored in external ack mode.
// - Later beats last one plus later waits; ignored in external ack mode.
// - Masked 17-bit compare against every valid bank picks attributes.
// - Lowest numbered matching bank wins.
// - Unmatched access: 32-bit, write enables, no burst, no muxing, external ack.
// - Narrow mode: unmatched 32-bit access runs as special two-beat burst.
// - No other burst writes; wide writes split per port width.
// - Watchdog flags timeout on externally acknowledged accesses, unmatched or to external ack banks.
// - Watchdog counts external bus clock cycles.
// - Timeout is two plus eight times the period setting.
// - Internally acknowledged chip-select accesses never run the watchdog.
// - Narrow mode treats every bank as a 16-bit port.
`timescale 1ns/1ns
module csbc_ctrl
   import csbc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic [31:0] req_addr,
   input wire logic req_write,
   input wire logic req_wide,
   output logic req_accept,
   output logic rsp_beat,
   output logic rsp_done,
   output logic rsp_err,
   input wire logic ext_clk,
   output logic [31:0] addr_out,
   output logic rd_wr_out,
   output logic addr_on_data_out,
   output logic start_out_n,
   output logic [3:0] bank_select_out_n,
   output logic [3:0] strobe_out_n,
   output logic burst_in_progress_out_n,
   output logic transfer_ack_o_n,
   output logic transfer_ack_oe,
   input wire logic transfer_ack_i_n
);
   logic [31:0] base_q [NBANK];
   logic [31:0] opt_q [NBANK];
   logic narrow_q, admux_q, wd_on_q, tmo_q;
   logic [7:0] wd_per_q;
   logic acc_q;
   logic [31:0] rdat;
   logic rhit;
   // Synchronisers: only stages 2 and 3 are read by logic
   logic eck1_q, eck2_q, eck3_q, ta1_q, ta2_q;
   logic e_rise;
   csbc_state_t st_q, st_d;
   logic [31:0] addr_q;
   logic [3:0] left_q, left_d, wcnt_q, wcnt_d;
   logic [10:0] wd_q, wd_d, wd_lim;
   logic hit_q, p16_q, strb_q, tog_q, xack_q, burst_q, mon_q, wr_q;
   logic [1:0] bank_q;
   logic [3:0] scy_q;
   logic [1:0] later_beat_waits_q;
   logic beat_ev, done_ev, err_ev, adv;
   // Match of the incoming request
   logic m_hit;
   logic [1:0] m_bank;
   logic [31:0] m_br, m_or;
   logic [16:0] m_mask;
   logic m_p16, m_xack, m_nob, m_burst;
   logic [3:0] m_units;
   logic [3:0] m_units_q;
   logic [31:0] req_addr_q;

   // Edges are found by sampling, so the bus clock must stay well below pclk/2;
   // all wait and watchdog counts are in sampled edges, exact only while that limit holds
   assign e_rise = eck2_q & ~eck3_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eck1_q <= 1'b0;
         eck2_q <= 1'b0;
         eck3_q <= 1'b0;
         ta1_q <= 1'b1;
         ta2_q <= 1'b1;
      end else begin
         eck1_q <= ext_clk;
         eck2_q <= eck1_q;
         eck3_q <= eck2_q;
         ta1_q <= transfer_ack_i_n;
         ta2_q <= ta1_q;
      end
   end

   // APB: two-cycle access, answer from flops one cycle into the access phase
   assign acc_q = psel & penable & pready;

   always_comb begin
      rdat = 32'h0000_0000;
      rhit = 1'b1;
      if (paddr == OFS_MODE) begin
         rdat[MODE_NARROW] = narrow_q;
         rdat[MODE_ADMUX] = admux_q;
      end else if (paddr == OFS_ERR) begin
         rdat[ERR_TIMEOUT] = tmo_q;
      end else if (paddr == OFS_STAT) begin
         rdat[0] = (st_q != CSBC_IDLE);
      end else if (paddr == OFS_WDOG) begin
         rdat[WDOG_PER_LO +: 8] = wd_per_q;
         rdat[WDOG_ON] = wd_on_q;
      end else if (paddr >= OFS_BANK && paddr < OFS_BANK_END && paddr[1:0] == 2'h0) begin
         rdat = paddr[2] ? opt_q[paddr[4:3]] : base_q[paddr[4:3]];
      end else begin
         rhit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rdat : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~rhit;
      end
   end

   // Writes while an access runs are the user's hazard; nothing blocks them here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         narrow_q <= 1'b0;
         admux_q <= 1'b0;
         wd_on_q <= 1'b0;
         wd_per_q <= WDOG_PER_RST;
         for (int i = 0; i < NBANK; i++) begin
            base_q[i] <= BR_RST;
            opt_q[i] <= OR_RST;
         end
      end else if (acc_q && pwrite && rhit) begin
         if (paddr == OFS_MODE) begin
            narrow_q <= pwdata[MODE_NARROW];
            admux_q <= pwdata[MODE_ADMUX];
         end else if (paddr == OFS_WDOG) begin
            wd_per_q <= pwdata[WDOG_PER_LO +: 8];
            wd_on_q <= pwdata[WDOG_ON];
         end else if (paddr >= OFS_BANK && paddr < OFS_BANK_END) begin
            if (paddr[2]) begin
               opt_q[paddr[4:3]] <= (pwdata & OR_WMASK) | {OR_MASK_FIX, 29'h0};
            end else begin
               base_q[paddr[4:3]] <= (pwdata & BR_WMASK) | {BR_ADDR_FIX, 29'h0};
            end
         end
      end
   end

   // Timeout flag: hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmo_q <= 1'b0;
      end else if (err_ev) begin
         tmo_q <= 1'b1;
      end else if (acc_q && pwrite && paddr == OFS_ERR && pwdata[ERR_TIMEOUT]) begin
         tmo_q <= 1'b0;
      end
   end

   // Bank match, scanned high to low so the lowest match is left standing
   always_comb begin
      m_hit = 1'b0;
      m_bank = 2'h0;
      for (int i = NBANK - 1; i >= 0; i--) begin
         m_mask = opt_q[i][31:OR_MASK_LO];
         if (base_q[i][BR_VALID] && ((req_addr[31:15] ^ base_q[i][31:BR_ADDR_LO]) & m_mask) == 17'h0) begin
            m_hit = 1'b1;
            m_bank = 2'(i);
         end
      end
      m_mask = 17'h0;
      m_br = base_q[m_bank];
      m_or = opt_q[m_bank];
      m_p16 = narrow_q | (m_hit & m_br[BR_PORT16]);
      m_xack = ~m_hit | m_br[BR_EXTACK];
      m_nob = ~m_hit | m_xack | m_br[BR_NOBURST];
      // Burst length bit is stored but ignored: every wide burst moves four words
      if (req_wide) begin
         m_units = m_p16 ? BEATS16 : BEATS32;
      end else begin
         m_units = m_p16 ? 4'h2 : 4'h1;
      end
      // Only full four-word reads or the special narrow case ever burst
      m_burst = (req_wide & ~req_write & ~m_nob) | (~m_hit & narrow_q & ~req_wide);
   end

   // Request acceptance latches the attributes of the selected bank or the defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_accept <= 1'b0;
         hit_q <= 1'b0;
         bank_q <= 2'h0;
         p16_q <= 1'b0;
         strb_q <= 1'b0;
         tog_q <= 1'b0;
         xack_q <= 1'b1;
         burst_q <= 1'b0;
         mon_q <= 1'b0;
         wr_q <= 1'b0;
         scy_q <= 4'h0;
         later_beat_waits_q <= 2'h0;
         addr_on_data_out <= 1'b0;
      end else begin
         req_accept <= 1'b0;
         if (st_q == CSBC_IDLE && req_valid && !req_accept) begin
            req_accept <= 1'b1;
            hit_q <= m_hit;
            bank_q <= m_bank;
            p16_q <= m_p16;
            strb_q <= m_hit & m_br[BR_STROBE];
            tog_q <= m_hit & m_br[BR_TOGGLE];
            xack_q <= m_xack;
            burst_q <= m_burst;
            mon_q <= wd_on_q & m_xack;
            wr_q <= req_write;
            scy_q <= m_or[OR_FIRST_LO +: 4];
            later_beat_waits_q <= m_or[OR_LATER_LO +: 2];
            addr_on_data_out <= m_hit ? m_br[BR_ADMUX] : 1'b0;
         end
      end
   end

   // Period is in steps of eight external cycles, so a shift stands in for a product
   assign wd_lim = 11'(WDOG_BASE) + {wd_per_q, 3'h0};

   // Cycle sequencer, stepped on sampled rising edges of the external bus clock
   always_comb begin
      st_d = st_q;
      left_d = left_q;
      wcnt_d = wcnt_q;
      wd_d = wd_q;
      beat_ev = 1'b0;
      done_ev = 1'b0;
      err_ev = 1'b0;
      adv = 1'b0;
      case (st_q)
         CSBC_IDLE: begin
            if (req_accept) begin
               st_d = CSBC_ADDR;
            end
         end
         // Address phase ends at the first sampled external rise after acceptance
         CSBC_ADDR: begin
            if (e_rise) begin
               st_d = CSBC_DATA;
               wcnt_d = xack_q ? 4'h0 : scy_q;
               wd_d = 11'h001;
            end
         end
         CSBC_DATA: begin
            if (e_rise) begin
               wd_d = wd_q + 11'h001;
               if (xack_q ? ~ta2_q : (wcnt_q == 4'h0)) begin
                  beat_ev = 1'b1;
                  if (left_q == 4'h1) begin
                     done_ev = 1'b1;
                     st_d = CSBC_IDLE;
                  end else begin
                     left_d = left_q - 4'h1;
                     adv = 1'b1;
                     if (burst_q) begin
                        wcnt_d = xack_q ? 4'h0 : {2'h0, later_beat_waits_q};
                     end else begin
                        st_d = CSBC_ADDR;
                     end
                  end
               end else if (mon_q && wd_q >= wd_lim) begin
                  err_ev = 1'b1;
                  done_ev = 1'b1;
                  st_d = CSBC_IDLE;
               end else if (wcnt_q != 4'h0) begin
                  wcnt_d = wcnt_q - 4'h1;
               end
            end
         end
         default: st_d = CSBC_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= CSBC_IDLE;
         left_q <= 4'h0;
         wcnt_q <= 4'h0;
         wd_q <= 11'h000;
         addr_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         wcnt_q <= wcnt_d;
         wd_q <= wd_d;
         if (req_accept) begin
            left_q <= m_units_q;
            addr_q <= req_addr_q;
         end else begin
            left_q <= left_d;
            if (adv && !burst_q) begin
               addr_q <= addr_q + (p16_q ? 32'h0000_0002 : 32'h0000_0004);
            end
         end
      end
   end

   // Request fields held from acceptance; the requester may drop them once taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_units_q <= 4'h0;
         req_addr_q <= 32'h0000_0000;
      end else if (st_q == CSBC_IDLE && req_valid && !req_accept) begin
         m_units_q <= m_units;
         req_addr_q <= req_addr;
      end
   end

   assign addr_out = addr_q;

   // Pin outputs are registered from the next state so they align with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_out_n <= 1'b1;
         bank_select_out_n <= 4'hf;
         strobe_out_n <= 4'hf;
         burst_in_progress_out_n <= 1'b1;
         transfer_ack_o_n <= 1'b1;
         transfer_ack_oe <= 1'b0;
         rd_wr_out <= 1'b1;
         rsp_beat <= 1'b0;
         rsp_done <= 1'b0;
         rsp_err <= 1'b0;
      end else begin
         start_out_n <= ~(st_d == CSBC_ADDR);
         bank_select_out_n <= ~((hit_q && st_d != CSBC_IDLE) ? (4'h1 << bank_q) : 4'h0);
         // Write enables only on writes; byte enables on both directions
         if (st_d == CSBC_DATA && (wr_q || strb_q)) begin
            strobe_out_n <= p16_q ? 4'hc : 4'h0;
         end else begin
            strobe_out_n <= 4'hf;
         end
         burst_in_progress_out_n <= ~(st_d == CSBC_DATA && burst_q && left_d > 4'h1
            && (!tog_q || wcnt_d <= {2'h0, later_beat_waits_q}));
         transfer_ack_oe <= (st_d != CSBC_IDLE) && !xack_q;
         transfer_ack_o_n <= ~(st_d == CSBC_DATA && !xack_q && wcnt_d == 4'h0);
         rd_wr_out <= ~wr_q;
         rsp_beat <= beat_ev;
         rsp_done <= done_ev;
         rsp_err <= err_ev;
      end
   end
endmodule : csbc_ctrl

/* verif/csbc_monitor.sv */
// Port checker for the bank controller.
// Sees only the top ports; attached by bind below.
`timescale 1ns/1ns
module csbc_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic req_accept,
   input wire logic rsp_done,
   input wire logic rsp_err,
   input wire logic start_out_n,
   input wire logic rd_wr_out,
   input wire logic [3:0] bank_select_out_n,
   input wire logic burst_in_progress_out_n,
   input wire logic transfer_ack_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_one_bank: assert property ($onehot0(~bank_select_out_n))
      else $error("two banks selected");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_slverr_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_err_done: assert property (rsp_err |-> rsp_done)
      else $error("error without done");
   a_err_extack: assert property (rsp_err |-> !transfer_ack_oe && !$past(transfer_ack_oe))
      else $error("timeout on internal ack access");
   a_noncs_extack: assert property (transfer_ack_oe |-> bank_select_out_n != 4'hf)
      else $error("internal ack without bank");
   a_no_burst_wr: assert property (!burst_in_progress_out_n && !rd_wr_out |-> bank_select_out_n == 4'hf)
      else $error("burst write to a bank");
   a_accept_start: assert property (req_accept |=> !start_out_n && !req_accept)
      else $error("accept without address phase");
endmodule : csbc_monitor
bind csbc_ctrl csbc_monitor u_mon (.pclk(pclk), .presetn(presetn), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .req_accept(req_accept), .rsp_done(rsp_done),
   .rsp_err(rsp_err), .start_out_n(start_out_n), .rd_wr_out(rd_wr_out),
   .bank_select_out_n(bank_select_out_n), .burst_in_progress_out_n(burst_in_progress_out_n),
   .transfer_ack_oe(transfer_ack_oe));

/* verif/csbc_ext_mem.sv */
// External memory model that acknowledges on the ack line.
// Assumes the line is pulled up whenever nobody drives it.
`timescale 1ns/1ns
module csbc_ext_mem (
   input wire logic ext_clk,
   input wire logic presetn,
   input wire logic start_out_n,
   input wire logic transfer_ack_oe,
   input wire logic [3:0] ack_wait,
   input wire logic ack_never,
   output logic ack_n
);
   logic busy_q;
   logic [3:0] cnt_q;
   always_ff @(posedge ext_clk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         ack_n <= 1'b1;
      end else if (!start_out_n) begin
         busy_q <= 1'b1;
         cnt_q <= 4'h0;
         ack_n <= 1'b1;
      end else if (busy_q && !transfer_ack_oe && !ack_never && cnt_q == ack_wait) begin
         busy_q <= 1'b0;
         ack_n <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         ack_n <= 1'b1;
      end
   end
endmodule : csbc_ext_mem

/* verif/csbc_ctrl_bench.sv */
// Bench for the chip-select bank controller.
// Drives APB and internal requests; the memory model answers those with external ack.
`timescale 1ns/1ns
module csbc_ctrl_bench import csbc_pkg::*;;
   localparam logic [31:0] CS_ADR = 32'h2000_0100;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_clk, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, req_addr, addr_out, rd;
   logic req_valid, req_write, req_wide, req_accept, rsp_beat, rsp_done, rsp_err;
   logic rd_wr_out, addr_on_data_out, start_out_n, bip_n, ack_o_n, ack_oe, mem_ack_n;
   logic [3:0] sel_n, strb_n, sel_seen, strb_seen, ack_wait;
   logic bst_seen, err_seen, ack_never, ack_line;
   int fails, samples_checked, beats, cyc, bst_cnt;
   assign ack_line = ack_oe ? ack_o_n : mem_ack_n;
   always #5 pclk = ~pclk;
   csbc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
      .req_wide(req_wide), .req_accept(req_accept), .rsp_beat(rsp_beat),
      .rsp_done(rsp_done), .rsp_err(rsp_err), .ext_clk(ext_clk), .addr_out(addr_out),
      .rd_wr_out(rd_wr_out), .addr_on_data_out(addr_on_data_out),
      .start_out_n(start_out_n), .bank_select_out_n(sel_n), .strobe_out_n(strb_n),
      .burst_in_progress_out_n(bip_n), .transfer_ack_o_n(ack_o_n),
      .transfer_ack_oe(ack_oe), .transfer_ack_i_n(ack_line));
   csbc_ext_mem u_mem (.ext_clk(ext_clk), .presetn(presetn), .start_out_n(start_out_n),
      .transfer_ack_oe(ack_oe), .ack_wait(ack_wait), .ack_never(ack_never),
      .ack_n(mem_ack_n));
   task automatic report_and_stop;
      $display("checks %0d bad %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   task automatic stuck;
      fails++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
   endtask : stuck
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) stuck();
   endtask : apb
   task automatic cfg(input int b, input logic [31:0] br, input logic [31:0] opt);
      apb(1'b1, OFS_BANK + 12'(8 * b), br);
      apb(1'b1, OFS_BANK + 12'(8 * b + 4), opt);
   endtask : cfg
   task automatic run_req(input logic [31:0] a, input logic w, input logic wide);
      int n;
      n = 0;
      @(posedge pclk);
      req_addr <= a;
      req_write <= w;
      req_wide <= wide;
      req_valid <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (req_accept !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      {beats, cyc, bst_cnt, sel_seen, strb_seen, bst_seen, err_seen} = '0;
      while (rsp_done !== 1'b1 && cyc < 5000) begin
         @(posedge pclk);
         cyc++;
         sel_seen |= ~sel_n;
         strb_seen |= ~strb_n;
         bst_seen |= ~bip_n;
         err_seen |= rsp_err;
         if (rsp_beat === 1'b1) beats++;
         if (bip_n === 1'b0) bst_cnt++;
      end
      if (n >= 50 || cyc >= 5000) stuck();
   endtask : run_req
   task automatic s_regs;
      apb(1'b0, OFS_BANK, 32'h0);
      chk(rd, BR_RST);
      apb(1'b0, OFS_BANK + 12'h4, 32'h0);
      chk(rd, OR_RST);
      apb(1'b1, OFS_BANK + 12'h4, 32'h0);
      apb(1'b0, OFS_BANK + 12'h4, 32'h0);
      chk(rd, 32'he000_0000);
      apb(1'b0, OFS_WDOG, 32'h0);
      chk(rd, 32'h0000_ff00);
      apb(1'b0, 12'h100, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      $display("registers done");
   endtask : s_regs
   task automatic s_burst;
      cfg(0, 32'h2000_0001, 32'hffff_8000);
      run_req(CS_ADR, 1'b0, 1'b1);
      chk(32'(beats), 32'h4);
      chk(32'(bst_seen), 32'h1);
      chk(32'(bst_cnt), 32'h18);
      apb(1'b1, OFS_MODE, 32'h1);
      run_req(CS_ADR, 1'b0, 1'b1);
      chk(32'(beats), 32'h8);
      apb(1'b1, OFS_MODE, 32'h0);
      cfg(0, 32'h2000_0003, 32'hffff_8000);
      run_req(CS_ADR, 1'b0, 1'b1);
      chk(32'(bst_seen), 32'h0);
      $display("bursts done");
   endtask : s_burst
   task automatic s_write;
      cfg(0, 32'h2000_0001, 32'hffff_8000);
      run_req(CS_ADR, 1'b1, 1'b1);
      chk(32'(beats), 32'h4);
      chk({strb_seen, 27'h0, bst_seen}, 32'hf000_0000);
      run_req(CS_ADR, 1'b0, 1'b0);
      chk(32'(strb_seen), 32'h0);
      cfg(0, 32'h2000_0021, 32'hffff_8000);
      run_req(CS_ADR, 1'b0, 1'b0);
      chk(32'(strb_seen), 32'hf);
      $display("writes done");
   endtask : s_write
   task automatic s_wait;
      cfg(0, 32'h2000_0091, 32'hffff_8022);
      run_req(CS_ADR, 1'b0, 1'b1);
      chk(32'(beats), 32'h4);
      chk(32'(cyc >= 72 && cyc <= 88), 32'h1);
      chk(32'(bst_cnt), 32'h30);
      chk({addr_out[31:1], addr_on_data_out}, {CS_ADR[31:1], 1'b1});
      $display("wait states done");
   endtask : s_wait
   task automatic s_extack;
      ack_wait <= 4'h3;
      cfg(0, 32'h2000_0005, 32'hffff_8000);
      run_req(CS_ADR, 1'b0, 1'b1);
      chk({28'(beats), sel_seen}, {28'h4, 4'h1});
      chk(32'(bst_seen), 32'h0);
      $display("external ack done");
   endtask : s_extack
   task automatic s_match;
      cfg(0, 32'h2000_0003, 32'hffff_8000);
      run_req(32'h2000_8000, 1'b0, 1'b0);
      chk(32'(sel_seen), 32'h0);
      apb(1'b1, OFS_BANK + 12'h4, 32'hffff_0000);
      run_req(32'h2000_8000, 1'b0, 1'b0);
      chk(32'(sel_seen), 32'h1);
      cfg(1, 32'h2000_0003, 32'hffff_8000);
      run_req(CS_ADR, 1'b0, 1'b0);
      chk(32'(sel_seen), 32'h1);
      apb(1'b1, OFS_BANK, 32'h2000_0002);
      run_req(CS_ADR, 1'b0, 1'b0);
      chk(32'(sel_seen), 32'h2);
      apb(1'b1, OFS_BANK + 12'h8, 32'h2000_0002);
      run_req(CS_ADR, 1'b0, 1'b0);
      chk({sel_seen, 27'(beats), err_seen}, 32'h2);
      $display("matching done");
   endtask : s_match
   task automatic s_wdog;
      apb(1'b1, OFS_WDOG, 32'h0000_0180);
      ack_never <= 1'b1;
      run_req(32'h4000_0000, 1'b0, 1'b0);
      chk(32'(err_seen), 32'h1);
      chk(32'(cyc >= 80 && cyc <= 112), 32'h1);
      apb(1'b0, OFS_ERR, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, OFS_ERR, 32'h1);
      apb(1'b0, OFS_ERR, 32'h0);
      chk(rd, 32'h0);
      ack_never <= 1'b0;
      $display("watchdog done");
   endtask : s_wdog
   initial begin
      {pclk, presetn, psel, penable, pwrite, req_valid, req_write, req_wide} = '0;
      {paddr, pwdata, req_addr, ack_wait, ack_never} = '0;
      {fails, samples_checked} = '0;
      ext_clk = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_burst();
      s_write();
      s_wait();
      s_extack();
      s_match();
      s_wdog();
      report_and_stop();
   end
   initial begin
      #3;
      forever #40 ext_clk = ~ext_clk;
   end
endmodule : csbc_ctrl_bench
